// file: tb/relay_output_override_tb.sv
// Self-checking bench for the relay override block.
`timescale 1ns/10ps
`default_nettype none
module relay_output_override_tb;
   import rlyov_pkg::*;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [6:0] relayInputs [6];
   logic [6:0] invertInputs [6];
   logic [5:0] relayAcknowledge = 6'h00;
   logic [5:0] latchEnable = 6'h00;
   logic [14:0] holdTime = 15'h0000;
   rlyov_timed_s inhibitCtrl = '0;
   rlyov_timed_s forceCtrl = '0;
   rlyov_force_e [5:0] forceState;
   logic inhibitEnable = 1'b0;
   logic supervisionIn = 1'b0;
   logic [5:0] relayOut;
   logic supervisionOut;
   logic inhibitActive;
   logic forceActive;
   logic [6:0] contact;
   int errors = 0;
   int testsRun = 0;
   // Device under test, with the relay contacts on its outputs.
   relay_output_override i_dut (.clock, .rst, .relayInputs, .invertInputs, .relayAcknowledge,
      .latchEnable, .holdTime, .inhibitCtrl, .inhibitEnable, .forceCtrl, .forceState,
      .supervisionIn, .relayOut, .supervisionOut, .inhibitActive, .forceActive);
   rlyov_relay_model i_relays (.clock, .coil({supervisionOut, relayOut}), .contact);
   // Free-running 100 MHz clock.
   initial
   begin
      forever #5 clock = ~clock;
   end
   task automatic check(input string name, input logic [6:0] exp, input logic [6:0] got);
      testsRun++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   // Inputs move 1 ns after the edge so the sampling edge never races them.
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic waitLow(input bit which);
      logic seen;
      seen = 1'b1;
      for (int i = 0; i < 10 && seen !== 1'b0; i++)
      begin
         step(1);
         seen = which ? forceActive : inhibitActive;
      end
      check("expiry", 7'h00, 7'(seen));
      if (seen !== 1'b0)
         print_verdict();
   endtask
   task automatic print_verdict();
      $display("Checks %0d errors %0d", testsRun, errors);
      if (errors == 0 && testsRun > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Main sequence: plain paths, force, inhibit, timeouts, latching.
   initial
   begin
      foreach (relayInputs[r])
      begin
         relayInputs[r] = 7'h00;
         invertInputs[r] = 7'h00;
         forceState[r] = RLYOV_FORCE_OFF;
      end
      step(20);
      rst = 1'b0;
      foreach (relayInputs[r])
         relayInputs[r] = 7'h02 << r;
      step(2);
      check("any", 7'h3f, 7'(relayOut));
      foreach (relayInputs[r])
         relayInputs[r] = 7'h00;
      invertInputs[2] = 7'h01;
      step(2);
      check("invert", 7'h04, 7'(relayOut));
      invertInputs[2] = 7'h00;
      foreach (relayInputs[r])
         relayInputs[r] = 7'h01;
      forceState[1] = RLYOV_FORCE_ON;
      forceState[2] = RLYOV_FORCE_NONE;
      forceCtrl.enable = 1'b1;
      step(2);
      check("force", 7'h06, 7'(relayOut));
      foreach (relayInputs[r])
         relayInputs[r] = 7'h00;
      step(2);
      check("forced", 7'h02, 7'(relayOut));
      supervisionIn = 1'b1;
      inhibitCtrl.enable = 1'b1;
      step(2);
      check("noEnable", 7'h01, 7'({inhibitActive, forceActive}));
      inhibitEnable = 1'b1;
      step(2);
      check("inhibit", 7'h00, 7'(relayOut));
      check("flags", 7'h02, 7'({inhibitActive, forceActive}));
      check("contacts", 7'h40, contact);
      forceCtrl.enable = 1'b0;
      step(1);
      forceCtrl.enable = 1'b1;
      step(10);
      check("refused", 7'h02, 7'({inhibitActive, forceActive}));
      forceCtrl.enable = 1'b0;
      inhibitCtrl.enable = 1'b0;
      relayInputs[4] = 7'h01;
      step(1);
      inhibitCtrl.mode = RLYOV_MODE_TIMEOUT;
      inhibitCtrl.enable = 1'b1;
      step(1);
      check("restart", 7'h01, 7'(inhibitActive));
      waitLow(1'b0);
      step(1);
      check("rearmed", 7'h10, 7'(relayOut));
      inhibitCtrl.enable = 1'b0;
      step(1);
      forceCtrl.mode = RLYOV_MODE_TIMEOUT;
      forceCtrl.enable = 1'b1;
      step(1);
      check("timedForce", 7'h02, 7'(relayOut));
      waitLow(1'b1);
      step(1);
      check("forceDone", 7'h10, 7'(relayOut));
      // An acknowledge while the input is still high must not release.
      forceCtrl.enable = 1'b0;
      latchEnable = 6'h08;
      relayInputs[3] = 7'h01;
      relayAcknowledge = 6'h08;
      step(3);
      check("ackEarly", 7'h18, 7'(relayOut));
      relayInputs[3] = 7'h00;
      relayAcknowledge = 6'h00;
      step(3);
      check("latched", 7'h18, 7'(relayOut));
      relayAcknowledge = 6'h08;
      step(3);
      check("released", 7'h10, 7'(relayOut));
      print_verdict();
   end
endmodule
bind relay_output_override rlyov_props i_props (.clock, .rst, .inhibitEnable, .inhibitCtrl,
   .forceCtrl, .forceState, .supervisionIn, .relayOut, .supervisionOut, .inhibitActive,
   .forceActive);
`default_nettype wire

// file: tb/rlyov_props.sv
// Port-level checks for the relay override block.
`timescale 1ns/10ps
`default_nettype none
module rlyov_props
   import rlyov_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic inhibitEnable,
   input wire rlyov_pkg::rlyov_timed_s inhibitCtrl,
   input wire rlyov_pkg::rlyov_timed_s forceCtrl,
   input wire rlyov_pkg::rlyov_force_e [5:0] forceState,
   input wire logic supervisionIn,
   input wire logic [5:0] relayOut,
   input wire logic supervisionOut,
   input wire logic inhibitActive,
   input wire logic forceActive
);
   logic [5:0] onMask;
   logic [5:0] offMask;
   // Masks let one check cover all six forced relays.
   always_comb
   begin
      for (int r = 0; r < 6; r++)
      begin
         onMask[r] = forceState[r] == RLYOV_FORCE_ON;
         offMask[r] = forceState[r] == RLYOV_FORCE_OFF;
      end
   end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   // Outputs lag their causes by one cycle, hence the past values.
   chk_inhibit_off: assert property (inhibitActive |-> relayOut == 6'h00)
      else $error("relay on under inhibit");
   chk_superv_live: assert property (
      inhibitActive |-> supervisionOut == $past(supervisionIn))
      else $error("supervision held");
   chk_inhibit_ends: assert property (
      $rose(inhibitActive) && inhibitCtrl.mode == RLYOV_MODE_TIMEOUT
      && inhibitCtrl.timeout == 15'h0000 |-> ##[1:4] !inhibitActive)
      else $error("timed inhibit stuck");
   chk_perm_inhibit: assert property (
      inhibitEnable && inhibitCtrl.enable && inhibitCtrl.mode == RLYOV_MODE_PERM
      |=> inhibitActive)
      else $error("permanent inhibit lost");
   chk_inhibit_start: assert property (
      $rose(inhibitEnable && inhibitCtrl.enable) |=> inhibitActive)
      else $error("inhibit not started");
   chk_no_force: assert property (inhibitActive |-> !forceActive)
      else $error("force under inhibit");
   chk_force_value: assert property (
      forceActive |-> (relayOut & $past(offMask)) == 6'h00
      && (relayOut & $past(onMask)) == $past(onMask))
      else $error("forced value wrong");
   chk_force_ends: assert property (
      $rose(forceActive) && forceCtrl.mode == RLYOV_MODE_TIMEOUT
      && forceCtrl.timeout == 15'h0000 |-> ##[1:4] !forceActive)
      else $error("timed force stuck");
   cover property ($rose(inhibitActive));
   cover property ($rose(forceActive));
   cover property ($fell(inhibitActive) && relayOut != 6'h00);
endmodule
`default_nettype wire

// file: tb/rlyov_relay_model.sv
// Relay contact model driven by the coil outputs.
`timescale 1ns/10ps
`default_nettype none
module rlyov_relay_model
(
   input wire logic clock,
   input wire logic [6:0] coil,
   output logic [6:0] contact
);
   // Contacts follow coils a clock late, standing in for armature travel.
   always_ff @(posedge clock)
   begin
      contact <= coil;
   end
endmodule
`default_nettype wire

// file: verilog/relay_output_override.sv
// Relay output logic with inhibit, force, inversion and latching.
`timescale 1ns/10ps
`default_nettype none
`include "rlyov_params.svh"
module relay_output_override
   import rlyov_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [6:0] relayInputs [6],
   input wire logic [6:0] invertInputs [6],
   input wire logic [5:0] relayAcknowledge,
   input wire logic [5:0] latchEnable,
   input wire logic [14:0] holdTime,
   input wire rlyov_pkg::rlyov_timed_s inhibitCtrl,
   input wire logic inhibitEnable,
   input wire rlyov_pkg::rlyov_timed_s forceCtrl,
   input wire rlyov_pkg::rlyov_force_e [5:0] forceState,
   input wire logic supervisionIn,
   output logic [5:0] relayOut,
   output logic supervisionOut,
   output logic inhibitActive,
   output logic forceActive
);
   import rlyov_pkg::*;

   // Returns true when any inverted-or-not input of a relay is active.
   function automatic logic anyAssigned(input logic [6:0] sig, input logic [6:0] inv);
      anyAssigned = |(sig ^ inv);
   endfunction

   logic [23:0] tickCount;
   logic [23:0] next_tickCount;
   logic tick;
   logic inhReq;
   logic inhReqQ;
   logic inhStart;
   logic inhExpired;
   logic inhDone;
   logic next_inhDone;
   logic next_inhibitActive;
   logic fReq;
   logic fReqQ;
   logic fStart;
   logic fExpired;
   logic fDone;
   logic next_fDone;
   logic next_forceActive;
   logic [5:0] raw;
   logic [5:0] latched;
   logic [5:0] next_latched;
   logic [5:0] next_relayOut;
   logic [5:0] holdStart;
   logic [5:0] holdOver;
   logic [5:0] prevRaw;

   // Common 10 ms tick for both duration timers and the six hold timers.
   // The tick phase runs free, so a timed period may end up to one tick early.
   always_comb
   begin
      next_tickCount = tickCount + 24'h000001;
      if (tickCount == 24'(`RLYOV_TICK_CYCLES - 1))
         next_tickCount = 24'h000000;
   end
   assign tick = tickCount == 24'(`RLYOV_TICK_CYCLES - 1);

   // Requests and their first cycles; force is refused while an inhibit request stands.
   assign inhReq = inhibitEnable && inhibitCtrl.enable;
   assign inhStart = inhReq && !inhReqQ;
   assign fReq = forceCtrl.enable && !inhReq;
   assign fStart = fReq && !fReqQ;

   rlyov_timer inhTimer
   (
      .clock(clock),
      .rst(rst),
      .start(inhStart),
      .tick(tick),
      .load(inhibitCtrl.timeout),
      .expired(inhExpired)
   );

   rlyov_timer forceTimer
   (
      .clock(clock),
      .rst(rst),
      .start(fStart),
      .tick(tick),
      .load(forceCtrl.timeout),
      .expired(fExpired)
   );

   // Inhibit and force state; a timed expiry holds until the request drops.
   always_comb
   begin
      next_inhDone = inhDone;
      // Permanent mode never times out, so a stale expiry is cleared here.
      if (!inhReq || inhStart || inhibitCtrl.mode == RLYOV_MODE_PERM)
         next_inhDone = 1'b0;
      else if (inhExpired && inhibitCtrl.mode == RLYOV_MODE_TIMEOUT)
         next_inhDone = 1'b1;
      next_inhibitActive = inhReq && !next_inhDone;
      next_fDone = fDone;
      if (!fReq || fStart || forceCtrl.mode == RLYOV_MODE_PERM)
         next_fDone = 1'b0;
      else if (fExpired && forceCtrl.mode == RLYOV_MODE_TIMEOUT)
         next_fDone = 1'b1;
      next_forceActive = fReq && !next_fDone && !next_inhibitActive;
   end

   // Latching with hold time per relay; hold runs from the raw rising edge.
   // An acknowledge is ignored while any assigned input is still active.
   always_comb
   begin
      for (int r = 0; r < 6; r++)
      begin
         raw[r] = anyAssigned(relayInputs[r], invertInputs[r]);
      end
      holdStart = raw & ~prevRaw;
      next_latched = latched;
      for (int r = 0; r < 6; r++)
      begin
         if (!latchEnable[r])
            next_latched[r] = 1'b0;
         else if (raw[r])
            next_latched[r] = 1'b1;
         else if (relayAcknowledge[r] && holdOver[r])
            next_latched[r] = 1'b0;
      end
      next_relayOut = 6'h00;
      for (int r = 0; r < 6; r++)
      begin
         if (next_inhibitActive)
            next_relayOut[r] = 1'b0;
         else if (next_forceActive && forceState[r] != RLYOV_FORCE_NONE)
            next_relayOut[r] = forceState[r] == RLYOV_FORCE_ON;
         else
            next_relayOut[r] = raw[r] | latched[r];
      end
   end

   // Hold timers, one per relay, reusing the shared tick.
   for (genvar g = 0; g < 6; g++)
   begin : holdGen
      logic hExp;
      logic hDone;
      logic next_hDone;
      rlyov_timer holdTimer
      (
         .clock(clock),
         .rst(rst),
         .start(holdStart[g]),
         .tick(tick),
         .load(holdTime),
         .expired(hExp)
      );
      // Hold is over once the timer expires; a new rising input restarts it.
      always_comb
      begin
         next_hDone = hDone | hExp;
         if (holdStart[g])
            next_hDone = 1'b0;
      end
      // Hold counts as over after reset, so an untouched relay can be
      // acknowledged at once.
      always_ff @(posedge clock or posedge rst)
      begin
         if (rst)
            hDone <= 1'b1;
         else
            hDone <= next_hDone;
      end
      assign holdOver[g] = hDone && !raw[g];
   end

   // Registers only.
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         tickCount <= 24'h000000;
         inhReqQ <= 1'b0;
         fReqQ <= 1'b0;
         inhDone <= 1'b0;
         fDone <= 1'b0;
         inhibitActive <= 1'b0;
         forceActive <= 1'b0;
         latched <= 6'h00;
         prevRaw <= 6'h00;
         relayOut <= 6'h00;
         supervisionOut <= 1'b0;
      end
      else
      begin
         tickCount <= next_tickCount;
         inhReqQ <= inhReq;
         fReqQ <= fReq;
         inhDone <= next_inhDone;
         fDone <= next_fDone;
         inhibitActive <= next_inhibitActive;
         forceActive <= next_forceActive;
         latched <= next_latched;
         prevRaw <= raw;
         relayOut <= next_relayOut;
         supervisionOut <= supervisionIn;
      end
   end
endmodule
`default_nettype wire

// file: verilog/rlyov_params.svh
// Constants for the relay output override block.
`ifndef RLYOV_PARAMS_SVH
`define RLYOV_PARAMS_SVH
`define RLYOV_NUM_RELAYS 6
`define RLYOV_NUM_INPUTS 7
`define RLYOV_CLK_HZ 100000000
`define RLYOV_TICK_MS 10
`define RLYOV_TICK_CYCLES ((`RLYOV_CLK_HZ / 1000) * `RLYOV_TICK_MS)
`define RLYOV_TIME_W 15
`define RLYOV_TIME_MAX 15'h7530
`define RLYOV_TIME_DEFAULT 15'h0003
`define RLYOV_HOLD_W 15
`define RLYOV_HOLD_DEFAULT 15'h0000
`endif

// file: verilog/rlyov_pkg.sv
// Types shared by the relay output override block.
`default_nettype none
package rlyov_pkg;
   typedef enum logic [1:0] {
      RLYOV_FORCE_NONE = 2'b00,
      RLYOV_FORCE_ON = 2'b01,
      RLYOV_FORCE_OFF = 2'b10
   } rlyov_force_e;
   typedef enum logic {
      RLYOV_MODE_PERM = 1'b0,
      RLYOV_MODE_TIMEOUT = 1'b1
   } rlyov_mode_e;
   typedef struct packed {
      logic enable;
      rlyov_mode_e mode;
      logic [14:0] timeout;
   } rlyov_timed_s;
endpackage
`default_nettype wire

// file: verilog/rlyov_timer.sv
// Countdown timer in 10 ms ticks used for inhibit and force durations and relay hold times.
`timescale 1ns/10ps
`default_nettype none
`include "rlyov_params.svh"
module rlyov_timer
(
   input wire logic clock,
   input wire logic rst,
   input wire logic start,
   input wire logic tick,
   input wire logic [14:0] load,
   output logic expired
);
   logic [14:0] count;
   logic [14:0] next_count;
   logic armed;
   logic next_armed;

   // A start reloads; each tick counts down, and a zero load expires on the cycle after the start.
   always_comb
   begin
      next_count = count;
      next_armed = armed;
      if (start)
      begin
         next_count = load;
         next_armed = 1'b1;
      end
      else if (armed && count == 15'h0000)
         next_armed = 1'b0;
      else if (armed && tick)
         next_count = count - 15'h0001;
   end

   // Registers only.
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         count <= 15'h0000;
         armed <= 1'b0;
      end
      else
      begin
         count <= next_count;
         armed <= next_armed;
      end
   end

   assign expired = armed && !start && count == 15'h0000;
endmodule
`default_nettype wire
